// File: dcs_defs.vh
// Purpose: offsets, field positions, reset values and counts of the dual counter serial block
// Assumes: 8-bit register port, byte offsets
// Notes: definitions only
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH
// register offsets
`define DCS_SERIAL_DATA 8'hf0
`define DCS_TIMER_MODE 8'hf1
`define DCS_COUNT1 8'hf2
`define DCS_PRESCALE1 8'hf3
`define DCS_COUNT0 8'hf4
`define DCS_PRESCALE0 8'hf5
`define DCS_LINE_MODE 8'hf6
`define DCS_PRIORITY 8'hf9
`define DCS_REQUEST 8'hfa
`define DCS_INT_MASK 8'hfb
// timer mode fields
`define DCS_TM_LOAD0 0
`define DCS_TM_RUN0 1
`define DCS_TM_LOAD1 2
`define DCS_TM_RUN1 3
`define DCS_TM_TIN_LO 4
`define DCS_TM_TIN_HI 5
// external timer input modes
`define DCS_TIN_CLOCK 2'h0
`define DCS_TIN_GATE 2'h1
`define DCS_TIN_TRIG 2'h2
`define DCS_TIN_RETRIG 2'h3
// prescaler fields
`define DCS_PS_CONT 0
`define DCS_PS_ALT 1
`define DCS_PS_RATIO_LO 2
// line mode fields
`define DCS_LM_SERIAL 0
`define DCS_LM_PARITY 1
`define DCS_LM_TIMER_OUTPUT_PIN 2
`define DCS_LM_TSEL_LO 3
`define DCS_LM_L4 6
`define DCS_LM_L5 7
// timer output sources
`define DCS_TSEL_C0 2'h0
`define DCS_TSEL_C1 2'h1
// interrupt mask global enable
`define DCS_IM_GLOBAL 7
// reset values
`define DCS_RESET_BYTE 8'h00
`define DCS_RESET_FRAME 11'h7ff
// counts
`define DCS_REQS 6
`define DCS_FRAME_BITS 4'hb
`define DCS_OVS_LAST 4'hf
`define DCS_OVS_MID 4'h7
`define DCS_RX_STOP 4'h9
`define DCS_INT_DIV_LAST 2'h3
`endif

// File: dcs_top.v
// Purpose: two 8-bit down-counters with prescalers, async serial port and six vectored requests
// Assumes: mclk 250 MHz, synchronous active-high reset, byte register port
// Notes: control lines 0..3 are inputs, 4..7 outputs; all outputs registered
`timescale 1ns/1ns
`include "dcs_defs.vh"
module dcs_top #(
    parameter NREQ = 6
) (
    input wire mclk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [3:0] line_in,
    output reg [3:0] line_out,
    output reg irq_valid,
    output reg [7:0] irq_vector,
    input wire irq_ack
);
    // software state
    reg [7:0] tmr_q;
    reg [7:0] init0_q;
    reg [7:0] init1_q;
    reg [7:0] ps0_q;
    reg [7:0] ps1_q;
    reg [7:0] mode_q;
    reg [2:0] pri_q;
    reg [5:0] req_q;
    reg [7:0] imr_q;
    reg [7:0] rx_data_q;
    // input synchroniser and edge history
    reg [3:0] sync1_q;
    reg [3:0] sync2_q;
    reg [3:0] prev_q;
    reg [1:0] div_q;
    reg intclk_q;
    reg [1:0] tog_q;
    wire [3:0] fall;
    wire external_timer_input;
    wire tin_rise;
    wire tick4;
    wire [1:0] tin_mode;
    wire [1:0] ch_src;
    wire [1:0] ch_load;
    wire [1:0] ch_run;
    wire [1:0] ch_cont;
    wire [15:0] ch_init;
    wire [11:0] ch_ratio;
    wire [1:0] ch_eoc;
    wire [1:0] ch_done;
    wire [15:0] ch_cnt;
    wire wr_tmr;
    // serial state
    reg [10:0] tx_sh;
    reg [3:0] tx_left;
    reg [3:0] tx_div;
    reg tx_done;
    reg rx_busy;
    reg [3:0] rx_div;
    reg [3:0] rx_bit;
    reg [7:0] rx_sh;
    reg rx_done;
    wire ser_en;
    wire par_en;
    wire rxd;
    // request selection
    reg sel_hit;
    reg [2:0] sel_idx;
    integer k;
    integer j;
    wire [5:0] avail;
    wire [5:0] set_req;
    wire grant;

    assign ser_en = mode_q[`DCS_LM_SERIAL];
    assign par_en = mode_q[`DCS_LM_PARITY];
    assign external_timer_input = sync2_q[1];
    assign rxd = sync2_q[0];
    assign fall = prev_q & ~sync2_q;
    assign tin_rise = external_timer_input & ~prev_q[1];
    assign tick4 = (div_q == `DCS_INT_DIV_LAST);
    assign tin_mode = tmr_q[`DCS_TM_TIN_HI:`DCS_TM_TIN_LO];
    assign wr_tmr = reg_wr && (reg_addr == `DCS_TIMER_MODE);

    // two-flop synchroniser for the input lines, then edge history
    always @(posedge mclk) begin
        if (reset) begin
            sync1_q <= 4'hf;
            sync2_q <= 4'hf;
            prev_q <= 4'hf;
        end else begin
            sync1_q <= line_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // internal clock divided by four, and its visible square wave
    always @(posedge mclk) begin
        if (reset) begin
            div_q <= 2'h0;
            intclk_q <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            if (div_q[0])
                intclk_q <= ~intclk_q;
        end
    end

    // per-counter controls; first counter only ever sees the internal tick
    assign ch_src[0] = tick4;
    assign ch_src[1] = ps0_q[`DCS_PS_ALT] ? ch_eoc[0] :
        !ps1_q[`DCS_PS_ALT] ? tick4 :
        (tin_mode == `DCS_TIN_CLOCK) ? tin_rise :
        (tin_mode == `DCS_TIN_GATE) ? (tick4 & external_timer_input) : tick4;
    assign ch_load[0] = wr_tmr & reg_wdata[`DCS_TM_LOAD0];
    assign ch_load[1] = (wr_tmr & reg_wdata[`DCS_TM_LOAD1]) |
        (ps1_q[`DCS_PS_ALT] & !ps0_q[`DCS_PS_ALT] & tin_rise &
        ((tin_mode == `DCS_TIN_RETRIG) | ((tin_mode == `DCS_TIN_TRIG) & ch_done[1])));
    assign ch_run = {tmr_q[`DCS_TM_RUN1], tmr_q[`DCS_TM_RUN0]};
    assign ch_cont = {ps1_q[`DCS_PS_CONT], ps0_q[`DCS_PS_CONT]};
    assign ch_init = {init1_q, init0_q};
    assign ch_ratio = {ps1_q[7:`DCS_PS_RATIO_LO], ps0_q[7:`DCS_PS_RATIO_LO]};

    // one prescaler and down-counter per channel
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            reg [5:0] pcnt_q;
            reg [7:0] cnt_q;
            reg done_q;
            reg eoc_q;
            wire [5:0] ratio;
            assign ratio = ch_ratio[6*g +: 6];
            assign ch_eoc[g] = eoc_q;
            assign ch_done[g] = done_q;
            assign ch_cnt[8*g +: 8] = cnt_q;
            always @(posedge mclk) begin
                if (reset) begin
                    pcnt_q <= 6'h00;
                    cnt_q <= 8'h00;
                    done_q <= 1'b1;
                    eoc_q <= 1'b0;
                end else begin
                    eoc_q <= 1'b0;
                    if (ch_load[g]) begin
                        cnt_q <= ch_init[8*g +: 8];
                        pcnt_q <= 6'h00;
                        done_q <= 1'b0;
                    end else if (ch_run[g] && !done_q && ch_src[g]) begin
                        // ratio field 0 wraps to 63 and so divides by 64
                        if (pcnt_q == ratio - 6'h01) begin
                            pcnt_q <= 6'h00;
                            if (cnt_q == 8'h01) begin
                                eoc_q <= 1'b1;
                                if (ch_cont[g]) begin
                                    cnt_q <= ch_init[8*g +: 8];
                                end else begin
                                    cnt_q <= 8'h00;
                                    done_q <= 1'b1;
                                end
                            end else begin
                                cnt_q <= cnt_q - 8'h01;
                            end
                        end else begin
                            pcnt_q <= pcnt_q + 6'h01;
                        end
                    end
                end
            end
        end
    endgenerate

    // counter output levels toggle on each end of count
    always @(posedge mclk) begin
        if (reset)
            tog_q <= 2'h0;
        else
            tog_q <= tog_q ^ ch_eoc;
    end

    // transmitter: sixteen first-counter ends of count per bit
    always @(posedge mclk) begin
        if (reset) begin
            tx_sh <= `DCS_RESET_FRAME;
            tx_left <= 4'h0;
            tx_div <= 4'h0;
            tx_done <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            if (reg_wr && reg_addr == `DCS_SERIAL_DATA && ser_en && tx_left == 4'h0) begin
                // stop, stop, data with optional odd parity in bit 7, start
                tx_sh <= {2'h3, (par_en ? ~^reg_wdata[6:0] : reg_wdata[7]), reg_wdata[6:0], 1'b0};
                tx_left <= `DCS_FRAME_BITS;
                tx_div <= 4'h0;
            end else if (ch_eoc[0] && tx_left != 4'h0) begin
                tx_div <= tx_div + 4'h1;
                if (tx_div == `DCS_OVS_LAST) begin
                    tx_sh <= {1'b1, tx_sh[10:1]};
                    tx_left <= tx_left - 4'h1;
                    if (tx_left == 4'h1)
                        tx_done <= 1'b1;
                end
            end
        end
    end

    // receiver: start found on an end of count, bits sampled mid-cell
    always @(posedge mclk) begin
        if (reset) begin
            rx_busy <= 1'b0;
            rx_div <= 4'h0;
            rx_bit <= 4'h0;
            rx_sh <= 8'h00;
            rx_done <= 1'b0;
            rx_data_q <= `DCS_RESET_BYTE;
        end else begin
            rx_done <= 1'b0;
            if (!rx_busy) begin
                if (ser_en && ch_eoc[0] && !rxd) begin
                    rx_busy <= 1'b1;
                    rx_div <= 4'h0;
                    rx_bit <= 4'h0;
                end
            end else if (ch_eoc[0]) begin
                rx_div <= rx_div + 4'h1;
                if (rx_div == `DCS_OVS_MID) begin
                    rx_bit <= rx_bit + 4'h1;
                    if (rx_bit == 4'h0) begin
                        if (rxd)
                            rx_busy <= 1'b0; // glitch, not a start bit
                    end else if (rx_bit == `DCS_RX_STOP) begin
                        // first stop cell ends the frame
                        rx_busy <= 1'b0;
                        rx_done <= 1'b1;
                        rx_data_q <= par_en ? {~^rx_sh, rx_sh[6:0]} : rx_sh;
                    end else begin
                        rx_sh <= {rxd, rx_sh[7:1]};
                    end
                end
            end
        end
    end

    // request sources, two of them shared
    assign set_req = {ch_eoc[1], ch_eoc[0] | tx_done, fall[3] | rx_done, fall[2:0]};
    assign avail = req_q & imr_q[5:0];

    // rotating priority: the priority register names the first request looked at
    always @* begin
        sel_hit = 1'b0;
        sel_idx = 3'h0;
        for (k = 0; k < 6; k = k + 1) begin
            j = pri_q + k;
            if (j >= 6)
                j = j - 6;
            if (j >= 6)
                j = j - 6;
            if (!sel_hit && avail[j]) begin
                sel_hit = 1'b1;
                sel_idx = j[2:0];
            end
        end
    end

    assign grant = imr_q[`DCS_IM_GLOBAL] && sel_hit && !irq_valid;

    // pending requests: a new event wins over the software clear
    always @(posedge mclk) begin
        if (reset)
            req_q <= 6'h00;
        else
            req_q <= (req_q & ~((reg_wr && reg_addr == `DCS_REQUEST) ? reg_wdata[5:0] : 6'h00)
                & ~(grant ? (6'h01 << sel_idx) : 6'h00)) | set_req;
    end

    // grant: hold vector location until acknowledged, drop global enable
    always @(posedge mclk) begin
        if (reset) begin
            irq_valid <= 1'b0;
            irq_vector <= 8'h00;
        end else if (grant) begin
            irq_valid <= 1'b1;
            irq_vector <= {4'h0, sel_idx, 1'b0};
        end else if (irq_ack) begin
            irq_valid <= 1'b0;
        end
    end

    // software writes; load bits of timer mode are pulses and never stored
    always @(posedge mclk) begin
        if (reset) begin
            tmr_q <= `DCS_RESET_BYTE;
            init0_q <= `DCS_RESET_BYTE;
            init1_q <= `DCS_RESET_BYTE;
            ps0_q <= `DCS_RESET_BYTE;
            ps1_q <= `DCS_RESET_BYTE;
            mode_q <= `DCS_RESET_BYTE;
            pri_q <= 3'h0;
            imr_q <= `DCS_RESET_BYTE;
        end else begin
            if (wr_tmr)
                tmr_q <= reg_wdata & 8'hfa;
            else if (reg_wr && reg_addr == `DCS_COUNT0)
                init0_q <= reg_wdata;
            else if (reg_wr && reg_addr == `DCS_COUNT1)
                init1_q <= reg_wdata;
            else if (reg_wr && reg_addr == `DCS_PRESCALE0)
                ps0_q <= reg_wdata;
            else if (reg_wr && reg_addr == `DCS_PRESCALE1)
                ps1_q <= reg_wdata;
            else if (reg_wr && reg_addr == `DCS_LINE_MODE)
                mode_q <= reg_wdata;
            else if (reg_wr && reg_addr == `DCS_PRIORITY)
                pri_q <= reg_wdata[2:0];
            if (grant)
                imr_q <= imr_q & 8'h7f;
            else if (reg_wr && reg_addr == `DCS_INT_MASK)
                imr_q <= reg_wdata;
        end
    end

    // read data stand in the cycle after the read strobe
    always @(posedge mclk) begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (!reg_rd)
            reg_rdata <= 8'h00;
        else if (reg_addr == `DCS_SERIAL_DATA)
            reg_rdata <= rx_data_q;
        else if (reg_addr == `DCS_TIMER_MODE)
            reg_rdata <= tmr_q;
        else if (reg_addr == `DCS_COUNT0)
            reg_rdata <= ch_cnt[7:0];
        else if (reg_addr == `DCS_COUNT1)
            reg_rdata <= ch_cnt[15:8];
        else if (reg_addr == `DCS_LINE_MODE)
            reg_rdata <= mode_q;
        else if (reg_addr == `DCS_PRIORITY)
            reg_rdata <= {5'h00, pri_q};
        else if (reg_addr == `DCS_REQUEST)
            reg_rdata <= {2'h0, req_q};
        else if (reg_addr == `DCS_INT_MASK)
            reg_rdata <= imr_q;
        else
            reg_rdata <= 8'h00; // prescalers and unmapped read zero
    end

    // output lines 4..7
    always @(posedge mclk) begin
        if (reset) begin
            line_out <= 4'h8;
        end else begin
            line_out[0] <= mode_q[`DCS_LM_L4];
            line_out[1] <= mode_q[`DCS_LM_L5];
            if (!mode_q[`DCS_LM_TIMER_OUTPUT_PIN])
                line_out[2] <= 1'b0;
            else if (mode_q[4:3] == `DCS_TSEL_C0)
                line_out[2] <= tog_q[0];
            else if (mode_q[4:3] == `DCS_TSEL_C1)
                line_out[2] <= tog_q[1];
            else
                line_out[2] <= intclk_q;
            line_out[3] <= ser_en ? tx_sh[0] : 1'b1;
        end
    end

endmodule

// File: dcs_remote.sv
// Purpose: remote serial device facing control lines 0 and 7
// Assumes: bit time learnt from the d0 cell of the first frame it hears, whose d0 must be 1 and d1 0
// Notes: idles at mark level between frames; samples the device on the falling clock edge
`timescale 1ns/1ns
module dcs_remote (
    input wire mclk,
    input wire tx_line,
    output reg rx_line,
    output reg [7:0] got,
    output reg got_ok,
    output reg [7:0] got_cnt
);
    int bitc;
    int n;
    int i0;
    reg [7:0] sh;
    reg s1;
    // listener: learn bit time, then take d0..d7 and both stop cells at mid cell
    initial begin
        rx_line = 1'b1;
        got = 8'h00;
        got_ok = 1'b0;
        got_cnt = 8'h00;
        bitc = 0;
        forever begin
            @(negedge mclk);
            if (tx_line === 1'b0) begin
                i0 = 0;
                if (bitc == 0) begin
                    // start cell follows the bit clock phase and may be cut short, so time the d0 cell
                    while (tx_line !== 1'b1) @(negedge mclk);
                    n = 0;
                    while (tx_line === 1'b1) begin
                        @(negedge mclk);
                        n++;
                    end
                    bitc = n;
                    sh[0] = 1'b1;
                    i0 = 1;
                    repeat (bitc / 2) @(negedge mclk);
                end else begin
                    repeat (bitc / 2 + bitc) @(negedge mclk);
                end
                for (int i = i0; i < 8; i++) begin
                    sh[i] = tx_line;
                    repeat (bitc) @(negedge mclk);
                end
                s1 = tx_line;
                repeat (bitc) @(negedge mclk);
                got = sh;
                got_ok = s1 & tx_line;
                got_cnt = got_cnt + 8'h01;
            end
        end
    end
    // sender: start, eight data bits lsb first, one stop cell, then mark
    task automatic send(input [7:0] b);
        @(posedge mclk);
        rx_line <= 1'b0;
        repeat (bitc) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            rx_line <= b[i];
            repeat (bitc) @(posedge mclk);
        end
        rx_line <= 1'b1;
        repeat (bitc) @(posedge mclk);
    endtask
endmodule

// File: dcs_top_chk.sv
// Purpose: port-level checks of the dual counter serial block
// Assumes: single clock domain, synchronous active-high reset
// Notes: mirrors the global enable bit to judge grants
`timescale 1ns/1ns
module dcs_top_chk #(
    parameter NREQ = 6
) (
    input wire mclk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire [3:0] line_in,
    input wire [3:0] line_out,
    input wire irq_valid,
    input wire [7:0] irq_vector,
    input wire irq_ack
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    reg glob_q;
    // global enable mirror, dropped once a grant is standing
    always @(posedge mclk) begin
        if (reset)
            glob_q <= 1'b0;
        else if (reg_wr && reg_addr == 8'hfb)
            glob_q <= reg_wdata[7];
        else if (irq_valid)
            glob_q <= 1'b0;
    end
    sequence s_grant_held;
        irq_valid && !irq_ack;
    endsequence
    sequence s_ack;
        irq_valid && irq_ack;
    endsequence
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    AST_PRESC_HIDDEN: assert property (reg_rd && (reg_addr == 8'hf3 || reg_addr == 8'hf5) |=> reg_rdata == 8'h00)
        else $error("prescaler contents visible");
    AST_UNMAPPED: assert property (reg_rd && (reg_addr < 8'hf0 || reg_addr == 8'hf7 || reg_addr == 8'hf8) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_VEC_RANGE: assert property (irq_valid |-> irq_vector < 2 * NREQ && !irq_vector[0])
        else $error("vector outside the twelve low bytes");
    AST_GRANT_HOLD: assert property (s_grant_held |=> irq_valid && $stable(irq_vector))
        else $error("grant dropped or vector moved before acknowledge");
    AST_ACK_DROP: assert property (s_ack |=> !irq_valid ##1 !irq_valid)
        else $error("grant not released after acknowledge");
    AST_GLOBAL: assert property ($rose(irq_valid) |-> glob_q)
        else $error("grant while globally disabled");
    AST_LINE45: assert property (reg_wr && reg_addr == 8'hf6 |-> ##2 line_out[1:0] == $past(reg_wdata[7:6], 2))
        else $error("lines 4 and 5 do not follow line mode");
endmodule
bind dcs_top dcs_top_chk #(.NREQ(NREQ)) u_chk (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_in(line_in),
    .line_out(line_out), .irq_valid(irq_valid), .irq_vector(irq_vector), .irq_ack(irq_ack));

// File: dcs_top_test.sv
// Purpose: register-level tests of counters, serial port and requests
// Assumes: 250 MHz mclk, reset held 12 cycles
// Notes: serial bit time is learnt by the remote model from the first frame
`timescale 1ns/1ns
module dcs_top_test;
    reg mclk;
    reg reset;
    reg [7:0] reg_addr;
    reg [7:0] reg_wdata;
    reg reg_wr;
    reg reg_rd;
    wire [7:0] reg_rdata;
    reg [3:0] line_in;
    wire [3:0] line_out;
    wire irq_valid;
    wire [7:0] irq_vector;
    reg irq_ack;
    wire rx_line;
    wire [7:0] got;
    wire got_ok;
    wire [7:0] got_cnt;
    int err_total;
    int compares;
    reg [7:0] r;
    reg [7:0] cnt0;
    reg [7:0] tx_bytes [4] = '{8'h55, 8'h3c, 8'h55, 8'h01};
    reg [7:0] tx_exp [4] = '{8'h55, 8'h3c, 8'hd5, 8'h01};
    dcs_top u_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_in(line_in), .line_out(line_out), .irq_valid(irq_valid),
        .irq_vector(irq_vector), .irq_ack(irq_ack));
    dcs_remote u_rem (.mclk(mclk), .tx_line(line_out[3]), .rx_line(rx_line), .got(got), .got_ok(got_ok),
        .got_cnt(got_cnt));
    // serial in comes from the remote model, other input lines rest high
    always @* line_in[0] = rx_line;
    task automatic wr(input [7:0] a, input [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, output [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        d = reg_rdata;
    endtask
    task automatic chk(input [7:0] seen, input [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches=%0d comparisons=%0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // watchdog
    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        report_and_stop;
    end
    // main sequence
    initial begin
        reset = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        line_in[3:1] = 3'h7;
        irq_ack = 1'b0;
        err_total = 0;
        compares = 0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        // reset values, hidden prescalers and an unmapped place
        for (int i = 0; i < 12; i++) begin
            rd(8'hf0 + i[7:0], r);
            chk(r, 8'h00);
        end
        rd(8'h10, r);
        chk(r, 8'h00);
        wr(8'hfb, 8'h5a);
        rd(8'hfb, r);
        chk(r, 8'h5a);
        // lines 4 and 5 follow line mode, timer output shows internal clock wave
        wr(8'hf6, 8'hd4);
        repeat (3) @(posedge mclk);
        chk({6'h00, line_out[1:0]}, 8'h03);
        cnt0 = 8'h00;
        r[0] = line_out[2];
        repeat (32) @(posedge mclk) if (line_out[2] !== r[0]) cnt0 = 8'h01;
        chk(cnt0, 8'h01);
        // second counter single pass from 5, request pollable while masked
        wr(8'hfb, 8'h00);
        wr(8'hf2, 8'h05);
        wr(8'hf3, 8'h04);
        wr(8'hf1, 8'h0c);
        repeat (200) @(posedge mclk);
        rd(8'hf2, r);
        chk(r, 8'h00);
        rd(8'hf2, r);
        chk(r, 8'h00);
        rd(8'hfa, r);
        chk(r & 8'h20, 8'h20);
        chk({7'h00, irq_valid}, 8'h00);
        // global enable grants, vector and acknowledge
        wr(8'hfb, 8'ha0);
        for (int i = 0; i < 20 && irq_valid !== 1'b1; i++) @(posedge mclk);
        chk({7'h00, irq_valid}, 8'h01);
        chk(irq_vector, 8'h0a);
        rd(8'hfb, r);
        chk(r, 8'h20);
        @(posedge mclk);
        irq_ack <= 1'b1;
        @(posedge mclk);
        irq_ack <= 1'b0;
        rd(8'hfa, r);
        chk(r & 8'h20, 8'h00);
        // transmit with first counter as bit clock, parity off then on
        wr(8'hf4, 8'h02);
        wr(8'hf5, 8'h05);
        wr(8'hf1, 8'h03);
        for (int k = 0; k < 4; k++) begin
            wr(8'hf6, k < 2 ? 8'h01 : 8'h03);
            cnt0 = got_cnt;
            wr(8'hf0, tx_bytes[k]);
            for (int i = 0; i < 20000 && got_cnt == cnt0; i++) @(posedge mclk);
            chk(got, tx_exp[k]);
            chk({7'h00, got_ok}, 8'h01);
            repeat (2 * u_rem.bitc) @(posedge mclk);
        end
        rd(8'hfa, r);
        chk(r & 8'h10, 8'h10);
        // receive, parity off then on with good and bad parity
        wr(8'hfa, 8'hff);
        wr(8'hf6, 8'h01);
        u_rem.send(8'h3c);
        repeat (2 * u_rem.bitc) @(posedge mclk);
        rd(8'hf0, r);
        chk(r, 8'h3c);
        rd(8'hfa, r);
        chk(r & 8'h08, 8'h08);
        wr(8'hf6, 8'h03);
        u_rem.send(8'h83);
        repeat (2 * u_rem.bitc) @(posedge mclk);
        rd(8'hf0, r);
        chk(r, 8'h03);
        u_rem.send(8'h03);
        repeat (2 * u_rem.bitc) @(posedge mclk);
        rd(8'hf0, r);
        chk(r, 8'h83);
        // cascade: second counter steps only on first counter ends of count
        wr(8'hf1, 8'h00);
        wr(8'hf5, 8'h07);
        rd(8'hf5, r);
        chk(r, 8'h00);
        wr(8'hf2, 8'h03);
        wr(8'hf3, 8'h04);
        wr(8'hf1, 8'h0c);
        repeat (100) @(posedge mclk);
        rd(8'hf2, r);
        chk(r, 8'h03);
        wr(8'hf1, 8'h0a);
        repeat (100) @(posedge mclk);
        rd(8'hf2, r);
        chk(r, 8'h00);
        // external input as gate of the internal clock
        wr(8'hf5, 8'h05);
        wr(8'hf3, 8'h06);
        line_in[1] <= 1'b0;
        wr(8'hf1, 8'h1c);
        repeat (100) @(posedge mclk);
        rd(8'hf2, r);
        chk(r, 8'h03);
        line_in[1] <= 1'b1;
        repeat (100) @(posedge mclk);
        rd(8'hf2, r);
        chk(r, 8'h00);
        // priority register names the request served first
        wr(8'hfa, 8'hff);
        wr(8'hf9, 8'h03);
        line_in[3:2] <= 2'h0;
        repeat (8) @(posedge mclk);
        line_in[3:2] <= 2'h3;
        for (int p = 0; p < 2; p++) begin
            wr(8'hfb, 8'h8c);
            for (int i = 0; i < 20 && irq_valid !== 1'b1; i++) @(posedge mclk);
            chk(irq_vector, p == 0 ? 8'h06 : 8'h04);
            @(posedge mclk);
            irq_ack <= 1'b1;
            @(posedge mclk);
            irq_ack <= 1'b0;
        end
        report_and_stop;
    end
endmodule
